// *** ompl_defines.vh ***
`ifndef OMPL_DEFINES_VH
`define OMPL_DEFINES_VH

// ****************************************************************
// Register byte offsets on the APB slave.
// ****************************************************************
`define OMPL_OFF_ACC      8'h00
`define OMPL_OFF_STATUS   8'h04
`define OMPL_OFF_BANKSEL  8'h08
`define OMPL_OFF_INSTR    8'h0C
`define OMPL_OFF_PTR0     8'h10
`define OMPL_OFF_PTR1     8'h14
`define OMPL_OFF_PTR2     8'h18
`define OMPL_OFF_STATE    8'h1C

// ****************************************************************
// Field positions.
// ****************************************************************
`define OMPL_STATUS_ZERO  0
`define OMPL_STATUS_NEG   1
`define OMPL_STATE_BUSY   0
`define OMPL_STATE_AWAIT  1
`define OMPL_STATE_ILLEG  2
`define OMPL_BIT_DEST     9
`define OMPL_BIT_BANK     8
`define OMPL_ACCESS_SPLIT 7

// ****************************************************************
// Reset values.
// ****************************************************************
`define OMPL_RST_ACC      8'h00
`define OMPL_RST_BANKSEL  8'h00
`define OMPL_RST_PTR      12'h000
`define OMPL_RST_INSTR    16'h0000

// ****************************************************************
// Opcode prefixes and the fixed access bank halves.
// ****************************************************************
`define OMPL_PFX_ORLIT    8'h09
`define OMPL_PFX_ORFILE   6'h04
`define OMPL_PFX_COPY     6'h14
`define OMPL_PFX_PTRHI    8'hEE
`define OMPL_PFX_PTRLO    8'hF0
`define OMPL_ACCESS_LOW   4'h0
`define OMPL_ACCESS_HIGH  4'hF

// ****************************************************************
// Internal operation codes and timing.
// ****************************************************************
`define OMPL_OP_NONE      3'h0
`define OMPL_OP_ORLIT     3'h1
`define OMPL_OP_ORFILE    3'h2
`define OMPL_OP_COPY      3'h3
`define OMPL_OP_PTRHI     3'h4
`define OMPL_OP_PTRLO     3'h5
`define OMPL_OP_BAD       3'h6
`define OMPL_PHASES       4

`endif

// *** ompl_alu.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ompl_defines.vh"

// ****************************************************************
// Result and flag logic for the decoded operation.
// ****************************************************************
module ompl_alu (
  input  wire [2:0] op,         // Decoded operation code.
  input  wire [7:0] acc,        // Accumulator value.
  input  wire [7:0] literal,    // Low byte of the instruction word.
  input  wire [7:0] fileData,   // Operand read from the file register.
  output reg  [7:0] result,     // Eight-bit result.
  output wire       negFlag,    // Negative flag of the result.
  output wire       zeroFlag    // Zero flag of the result.
);

  // Select the operation; unused operations pass the literal through.
  always @* begin
    case (op)
      `OMPL_OP_ORLIT:  result = acc | literal;  // RULE1
      `OMPL_OP_ORFILE: result = acc | fileData; // RULE2
      `OMPL_OP_COPY:   result = fileData;       // RULE9
      default:         result = literal;
    endcase
  end

  // Flags follow the eight result bits only.
  assign negFlag  = result[7];        // RULE11
  assign zeroFlag = (result == 8'h00); // RULE11

endmodule // ompl_alu

`default_nettype wire

// *** ompl_exec.v ***
// Behaviour
// RULE1 - Literal OR into accumulator, result to accumulator
// RULE2 - OR accumulator with addressed file register
// RULE3 - Destination bit: 0 accumulator, 1 file register
// RULE4 - Bank bit 0 access bank, 1 bank selector
// RULE5 - Eight-bit operand is offset within bank
// RULE6 - N and Z updated; pointer load leaves flags
// RULE7 - Pointer load is two words, two cycles
// RULE8 - Twelve-bit literal split into pointer halves
// RULE9 - Copy file register to selected destination
// RULE10 - Four phases: decode, read, process, write
// RULE11 - N from bit 7, Z when zero
`timescale 1ns/1ps
`default_nettype none
`include "ompl_defines.vh"

module ompl_exec (
  input  wire        clk,          // 40 MHz core clock.
  input  wire        rstn,         // Asynchronous reset, active low.
  input  wire        ce,           // Clock enable; low freezes all state.
  input  wire        psel,         // APB select.
  input  wire        penable,      // APB enable.
  input  wire        pwrite,       // APB direction, high for write.
  input  wire [7:0]  paddr,        // APB byte address.
  input  wire [31:0] pwdata,       // APB write data.
  output reg  [31:0] prdata,       // APB read data.
  output wire        pready,       // APB ready.
  output reg         pslverr,      // APB error.
  output reg  [11:0] fileAddr,     // File register address.
  output reg         fileRe,       // File register read strobe.
  input  wire [7:0]  fileRdData,   // Read data, one cycle after fileRe.
  output reg         fileWe,       // File register write strobe.
  output reg  [7:0]  fileWrData,   // File register write data.
  output reg  [7:0]  accOut,       // Accumulator.
  output wire [35:0] ptrOut,       // Pointers 2..0, twelve bits each.
  output reg         busy          // An instruction is in progress.
);

  // ****************************************************************
  // State.
  // ****************************************************************
  reg  [1:0]  phaseQ;              // Current phase of the instruction cycle.
  reg  [15:0] instrQ;              // Instruction word being executed.
  reg  [7:0]  bankSelQ;            // Bank selector register.
  reg         negQ;                // Negative flag.
  reg         zeroQ;               // Zero flag.
  reg         awaitLowQ;           // First pointer word seen, waiting for second.
  reg  [1:0]  ptrSelQ;             // Pointer chosen by the first word.
  reg         illegalQ;            // Sticky: an unknown or misplaced word.
  reg  [7:0]  resQ;                // Result captured in the process phase.
  reg         resNegQ;             // Negative flag of resQ.
  reg         resZeroQ;            // Zero flag of resQ.
  reg  [11:0] ptrQ [0:2];          // Indirect pointers; high nibble is the high byte.
  reg  [2:0]  decOp;               // Decoded operation.
  reg  [11:0] bankAddr;            // Full address of the file operand.
  reg  [31:0] readMux;             // Read data before registering.
  reg         mapped;              // Address hits a register.
  wire [7:0]  aluRes;              // Result from the ALU.
  wire        aluNeg;              // Negative flag from the ALU.
  wire        aluZero;             // Zero flag from the ALU.
  reg         answerQ;             // Answer loaded for the current APB transfer.
  wire        wrDone;              // APB write takes effect this edge.
  wire        issue;               // A new instruction word is accepted.
  wire        destFile;            // Destination bit of the instruction.
  wire        fileOp;              // Operation reads a file register.
  wire        flagOp;              // Operation updates N and Z.

  // ****************************************************************
  // Decode.
  // ****************************************************************

  // Classify the held word; a stray second word or a missing one is illegal.
  always @* begin
    decOp = `OMPL_OP_BAD;
    if (awaitLowQ) begin
      if (instrQ[15:8] == `OMPL_PFX_PTRLO) begin
        decOp = `OMPL_OP_PTRLO; // RULE7
      end
    end else if (instrQ[15:8] == `OMPL_PFX_ORLIT) begin
      decOp = `OMPL_OP_ORLIT; // RULE1
    end else if (instrQ[15:10] == `OMPL_PFX_ORFILE) begin
      decOp = `OMPL_OP_ORFILE; // RULE2
    end else if (instrQ[15:10] == `OMPL_PFX_COPY) begin
      decOp = `OMPL_OP_COPY; // RULE9
    end else if (instrQ[15:8] == `OMPL_PFX_PTRHI && instrQ[7:6] == 2'b00 && instrQ[5:4] != 2'b11) begin
      decOp = `OMPL_OP_PTRHI; // RULE7
    end
  end

  // Form the operand address; the access bank splits at offset 0x80.
  always @* begin
    if (instrQ[`OMPL_BIT_BANK]) begin
      bankAddr = {bankSelQ[3:0], instrQ[7:0]}; // RULE4 RULE5
    end else if (instrQ[`OMPL_ACCESS_SPLIT]) begin
      bankAddr = {`OMPL_ACCESS_HIGH, instrQ[7:0]}; // RULE4
    end else begin
      bankAddr = {`OMPL_ACCESS_LOW, instrQ[7:0]}; // RULE4
    end
  end

  assign destFile = instrQ[`OMPL_BIT_DEST];
  assign fileOp   = (decOp == `OMPL_OP_ORFILE) || (decOp == `OMPL_OP_COPY);
  assign flagOp   = fileOp || (decOp == `OMPL_OP_ORLIT); // RULE6

  ompl_alu uAlu (
    .op       (decOp),
    .acc      (accOut),
    .literal  (instrQ[7:0]),
    .fileData (fileRdData),
    .result   (aluRes),
    .negFlag  (aluNeg),
    .zeroFlag (aluZero)
  );

  // ****************************************************************
  // APB slave.
  // ****************************************************************

  // Ready waits for a loaded answer; frozen cycles hold the master in its access phase.
  assign pready  = ce && answerQ;
  assign wrDone  = pready && psel && penable && pwrite && !pslverr;
  assign issue   = wrDone && (paddr == `OMPL_OFF_INSTR);

  // Read data is chosen from the address held during setup.
  always @* begin
    mapped  = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      `OMPL_OFF_ACC:     readMux[7:0] = accOut;
      `OMPL_OFF_STATUS:  readMux[1:0] = {negQ, zeroQ};
      `OMPL_OFF_BANKSEL: readMux[7:0] = bankSelQ;
      `OMPL_OFF_INSTR:   readMux[15:0] = instrQ;
      `OMPL_OFF_PTR0:    readMux[11:0] = ptrQ[0];
      `OMPL_OFF_PTR1:    readMux[11:0] = ptrQ[1];
      `OMPL_OFF_PTR2:    readMux[11:0] = ptrQ[2];
      `OMPL_OFF_STATE:   readMux[2:0] = {illegalQ, awaitLowQ, busy};
      default:           mapped = 1'b0;
    endcase
  end

  // Register the answer at the first enabled edge of a transfer, normally its
  // setup edge, so prdata comes from a flop with no wait state. A setup edge
  // lost to a low clock enable costs one wait state instead of stale data.
  // Writes other than the state register are refused while busy, so software
  // never races the write phase of an instruction.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      answerQ <= 1'b0;
    end else if (ce) begin
      if (psel && !answerQ) begin
        prdata  <= pwrite ? 32'h00000000 : readMux;
        pslverr <= !mapped || (pwrite && busy && paddr != `OMPL_OFF_STATE);
        answerQ <= 1'b1;
      end else if (psel && penable) begin
        answerQ <= 1'b0; // The transfer completes at this edge.
      end
    end
  end

  // ****************************************************************
  // Phase sequencer and file register port.
  // ****************************************************************

  // One instruction word runs Q1 to Q4 over four clock cycles.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy       <= 1'b0;
      phaseQ     <= 2'b00;
      instrQ     <= `OMPL_RST_INSTR;
      fileAddr   <= 12'h000;
      fileRe     <= 1'b0;
      fileWe     <= 1'b0;
      fileWrData <= 8'h00;
      resQ       <= 8'h00;
      resNegQ    <= 1'b0;
      resZeroQ   <= 1'b0;
    end else if (ce) begin
      fileRe <= 1'b0;
      fileWe <= 1'b0;
      if (issue) begin
        instrQ <= pwdata[15:0];
        busy   <= 1'b1;
        phaseQ <= 2'b00;
      end else if (busy) begin
        phaseQ <= phaseQ + 2'b01;
        case (phaseQ)
          2'b00: begin
            fileAddr <= bankAddr; // RULE10 RULE5
            fileRe   <= fileOp;
          end
          2'b01: begin
            // Read phase: the file register answers during the next cycle.
          end
          2'b10: begin
            resQ       <= aluRes; // RULE10
            resNegQ    <= aluNeg;
            resZeroQ   <= aluZero;
            fileWe     <= fileOp && destFile; // RULE3
            fileWrData <= aluRes;
          end
          default: begin
            busy <= 1'b0; // RULE10
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Architectural registers, written in Q4 or by software when idle; a state register write also clears while busy, except in Q4.
  // ****************************************************************

  // Accumulator, flags, bank selector and the pointer-load sequence state.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accOut    <= `OMPL_RST_ACC;
      negQ      <= 1'b0;
      zeroQ     <= 1'b0;
      bankSelQ  <= `OMPL_RST_BANKSEL;
      awaitLowQ <= 1'b0;
      ptrSelQ   <= 2'b00;
      illegalQ  <= 1'b0;
    end else if (ce) begin
      if (busy && phaseQ == 2'b11) begin
        if (decOp == `OMPL_OP_ORLIT || (fileOp && !destFile)) begin
          accOut <= resQ; // RULE1 RULE3 RULE9
        end
        if (flagOp) begin
          negQ  <= resNegQ; // RULE6
          zeroQ <= resZeroQ; // RULE6
        end
        awaitLowQ <= (decOp == `OMPL_OP_PTRHI); // RULE7
        if (decOp == `OMPL_OP_PTRHI) begin
          ptrSelQ <= instrQ[5:4];
        end
        if (decOp == `OMPL_OP_BAD) begin
          illegalQ <= 1'b1;
        end
      end else begin
        if (wrDone && paddr == `OMPL_OFF_ACC) begin
          accOut <= pwdata[7:0];
        end
        if (wrDone && paddr == `OMPL_OFF_STATUS) begin
          negQ  <= pwdata[`OMPL_STATUS_NEG];
          zeroQ <= pwdata[`OMPL_STATUS_ZERO];
        end
        if (wrDone && paddr == `OMPL_OFF_BANKSEL) begin
          bankSelQ <= pwdata[7:0];
        end
        // Write one to clear; a setting event above takes priority.
        if (wrDone && paddr == `OMPL_OFF_STATE && pwdata[`OMPL_STATE_ILLEG]) begin
          illegalQ <= 1'b0;
        end
      end
    end
  end

  // One pointer per generate entry; high nibble in Q4 of word one, low byte
  // in Q4 of word two.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gPtr
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ptrQ[gi] <= `OMPL_RST_PTR;
        end else if (ce) begin
          if (busy && phaseQ == 2'b11 && decOp == `OMPL_OP_PTRHI && instrQ[5:4] == gi) begin
            ptrQ[gi][11:8] <= instrQ[3:0]; // RULE8
          end else if (busy && phaseQ == 2'b11 && decOp == `OMPL_OP_PTRLO && ptrSelQ == gi) begin
            ptrQ[gi][7:0] <= instrQ[7:0]; // RULE8
          end else if (wrDone && paddr == (`OMPL_OFF_PTR0 + 8'h04 * gi)) begin
            ptrQ[gi] <= pwdata[11:0];
          end
        end
      end
      assign ptrOut[gi*12 +: 12] = ptrQ[gi];
    end
  endgenerate

endmodule // ompl_exec

`default_nettype wire

// *** ompl_exec_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ompl_defines.vh"
// ********************
// Checker for the execute block.
// ********************
module ompl_exec_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] fileAddr,
  input wire logic        fileRe,
  input wire logic [7:0]  fileRdData,
  input wire logic        fileWe,
  input wire logic [7:0]  fileWrData,
  input wire logic [7:0]  accOut,
  input wire logic [35:0] ptrOut,
  input wire logic        busy
);
  logic        wrHit;   // An accepted write lands at this edge.
  logic [15:0] instr_q; // Word now executing.
  logic [15:0] prev_q;  // Word executed before it.
  logic [7:0]  bank_q;  // Bank selector as software left it.
  assign wrHit = psel && penable && pwrite && pready && !pslverr;
  // Shadow copies; instruction and bank selector writes while busy are refused, so they are skipped here too.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      instr_q <= `OMPL_RST_INSTR;
      prev_q  <= `OMPL_RST_INSTR;
      bank_q  <= `OMPL_RST_BANKSEL;
    end else if (wrHit && !busy) begin
      if (paddr == `OMPL_OFF_INSTR) begin
        prev_q  <= instr_q;
        instr_q <= pwdata[15:0];
      end
      if (paddr == `OMPL_OFF_BANKSEL) bank_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_re_pulse; fileRe |=> !fileRe; endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("read strobe too long");
  property p_busy4; $rose(busy) |-> busy[*4] ##1 !busy; endproperty
  a_busy4: assert property (p_busy4) else $error("instruction not four phases");
  property p_we_time; fileWe |-> $past(fileRe, 2); endproperty
  a_we_time: assert property (p_we_time) else $error("write not two cycles after read");
  property p_we_dest; fileWe |-> instr_q[`OMPL_BIT_DEST]; endproperty
  a_we_dest: assert property (p_we_dest) else $error("file written with dest bit low");
  property p_wdata;
    fileWe |-> fileWrData == ($past(fileRdData) | (instr_q[15:10] == `OMPL_PFX_ORFILE ? accOut : 8'h00));
  endproperty
  a_wdata: assert property (p_wdata) else $error("file write data wrong");
  property p_offset; fileRe |-> fileAddr[7:0] == instr_q[7:0]; endproperty
  a_offset: assert property (p_offset) else $error("file offset wrong");
  property p_bank;
    fileRe |-> fileAddr[11:8] == (instr_q[`OMPL_BIT_BANK] ? bank_q[3:0]
      : (instr_q[7] ? `OMPL_ACCESS_HIGH : `OMPL_ACCESS_LOW));
  endproperty
  a_bank: assert property (p_bank) else $error("bank wrong");
  property p_orlit;
    $fell(busy) && instr_q[15:8] == `OMPL_PFX_ORLIT && prev_q[15:8] != `OMPL_PFX_PTRHI
      |-> accOut == ($past(accOut) | instr_q[7:0]);
  endproperty
  a_orlit: assert property (p_orlit) else $error("literal OR result wrong");
  property p_ptr;
    $changed(ptrOut) |-> $fell(busy) || $past(wrHit && paddr >= `OMPL_OFF_PTR0 && paddr <= `OMPL_OFF_PTR2);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer changed outside write phase");
endmodule // ompl_exec_asserts
bind ompl_exec ompl_exec_asserts i_chk (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fileAddr(fileAddr), .fileRe(fileRe), .fileRdData(fileRdData), .fileWe(fileWe), .fileWrData(fileWrData),
  .accOut(accOut), .ptrOut(ptrOut), .busy(busy));
`default_nettype wire

// *** or_move_pointer_load_exec_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ompl_defines.vh"
// ********************
// Random bench for the execute block.
// ********************
module or_move_pointer_load_exec_bench;
  logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr, fileRe, fileWe, busy, err;
  logic [7:0]  paddr, fileRdData, fileWrData, accOut, acc, bank, k, r, res;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [11:0] fileAddr, fa;
  logic [35:0] ptrOut, ptrs;  // Expected pointers.
  logic [15:0] w;
  logic [1:0]  op, sel, flg;  // Flags kept as {negative, zero}.
  logic [7:0]  mem [0:4095];  // File registers.
  int          bad_count, checks_done, cycles;
  ompl_exec i_dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fileAddr(fileAddr), .fileRe(fileRe), .fileRdData(fileRdData), .fileWe(fileWe),
    .fileWrData(fileWrData), .accOut(accOut), .ptrOut(ptrOut), .busy(busy));
  // Data answers the cycle after the strobe; otherwise it shows the inverse so stale data never matches.
  always @(posedge clk) begin
    fileRdData <= fileRe ? mem[fileAddr] : ~mem[fileAddr];
    if (fileWe) mem[fileAddr] <= fileWrData;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  function automatic logic [7:0] rb();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [11:0] fAddr(logic [15:0] x, logic [7:0] b);
    return {x[8] ? b[3:0] : (x[7] ? `OMPL_ACCESS_HIGH : `OMPL_ACCESS_LOW), x[7:0]};
  endfunction
  function automatic logic [1:0] flags(logic [7:0] v);
    return {v[7], v == 8'h00};
  endfunction
  task automatic check(logic [35:0] seen, logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(logic [7:0] a, logic wr, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic idle();
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask
  task automatic issue(logic [15:0] x);
    apb(`OMPL_OFF_INSTR, 1'b1, {16'h0000, x});
    idle();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    seed = 32'h4D5A; rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; ptrs = 36'h0; flg = 2'b00;
    bad_count = 0; checks_done = 0; cycles = 0;
    for (int i = 0; i < 4096; i++) mem[i] = rb();
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // Random mix; the first pass is a literal OR so the flags start known.
    for (int i = 0; i < 40; i++) begin
      acc = rb();
      apb(`OMPL_OFF_ACC, 1'b1, {24'h0, acc});
      bank = rb();
      apb(`OMPL_OFF_BANKSEL, 1'b1, {24'h0, bank});
      k = rb();
      r = seed[15:8];
      op = (i == 0) ? 2'd0 : r[1:0];
      w = {6'h00, r[3:2], k};
      fa = fAddr(w, bank);
      case (op)
        2'd0: begin w = {`OMPL_PFX_ORLIT, k}; res = acc | k; end
        2'd1: begin w = {`OMPL_PFX_ORFILE, w[9:0]}; res = acc | mem[fa]; end
        2'd2: begin w = {`OMPL_PFX_COPY, w[9:0]}; res = mem[fa]; end
        default: begin
          sel = 2'(i % 3);
          ptrs[12*sel +: 12] = {r[7:4], k};
          issue({`OMPL_PFX_PTRHI, 2'b00, sel, r[7:4]});
          w = {`OMPL_PFX_PTRLO, k};
        end
      endcase
      issue(w);
      if (op == 2'd3) begin
        apb(`OMPL_OFF_PTR0 + {4'h0, sel, 2'b00}, 1'b0, 32'h0);
        check(rd, {20'h0, ptrs[12*sel +: 12]});
      end else if (op != 2'd0 && w[9]) check(mem[fa], res);
      else acc = res;
      if (op != 2'd3) flg = flags(res);
      check(accOut, acc);
      check(ptrOut, ptrs);
      apb(`OMPL_OFF_STATUS, 1'b0, 32'h0);
      check(rd, {30'h0, flg});
    end
    $display("random mix done");
    // Select value three names no pointer.
    issue({`OMPL_PFX_PTRHI, 8'h3A});
    apb(`OMPL_OFF_STATE, 1'b0, 32'h0);
    check(rd[2], 1'b1);
    check(ptrOut, ptrs);
    // A first word not followed by its second: only the high half lands.
    issue({`OMPL_PFX_PTRHI, 8'h15});
    ptrs[23:20] = 4'h5;
    issue({`OMPL_PFX_ORLIT, 8'hFF});
    check(ptrOut, ptrs);
    check(accOut, acc);
    // A register write during execution is refused.
    apb(`OMPL_OFF_INSTR, 1'b1, 32'h0000_0900);
    apb(`OMPL_OFF_ACC, 1'b1, 32'h0000_00FF);
    check(err, 1'b1);
    idle();
    check(accOut, acc);
    apb(8'h20, 1'b0, 32'h0);
    check(err, 1'b1);
    // A setup edge lost to a low clock enable must still give a clean answer.
    fork
      apb(`OMPL_OFF_ACC, 1'b1, 32'h0000_005A);
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    check(err, 1'b0);
    apb(`OMPL_OFF_ACC, 1'b0, 32'h0);
    check(rd, 32'h0000_005A);
    check(err, 1'b0);
    $display("corner cases done");
    summarize();
  end
endmodule // or_move_pointer_load_exec_bench
`default_nettype wire
